// file: hw/ccpm_top.sv
// Two capture/compare units with their register file behind AXI4-Lite.
// Assumes the timer count and ADC enable come from logic on aclk;
// the unit pins come from pads and are synchronised here.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Two identical units, own registers and flag
// - Mode 0000 shuts unit off, resets state
// - Mode 0010 toggles output on match
// - Mode 1000 drives output high on match
// - Mode 1001 drives output low on match
// - Mode 1010 match sets flag only
// - Mode 1011 match resets timer
// - Duty low bits used only in PWM
// - Capture copies full 16-bit timer count
// - Mode 0100 captures every falling edge
// - Mode 0101 captures every rising edge
// - Modes 0110/0111 capture per 4/16 rises
// - Capture sets flag; only software clears
// - New capture silently overwrites old value
// - Driven pin level changes can cause capture
// - Prescaler cleared when off or leaving capture
// - Ratio change keeps prescaler count
// - Compare watches capture pair against timer
// - Trigger starts conversion when ADC enabled
module ccpm_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ccpm_pkg::CCPM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ccpm_pkg::CCPM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ccpm_pkg::CCPM_NUM_INST-1:0] ccp_pin_in,
	output logic [ccpm_pkg::CCPM_NUM_INST-1:0] ccp_pin_out,
	output logic [ccpm_pkg::CCPM_NUM_INST-1:0] ccp_pin_oe,
	input wire logic [15:0] timer_count,
	input wire logic adc_enable,
	output logic [ccpm_pkg::CCPM_NUM_INST-1:0] timer_reset,
	output logic adc_go_set,
	output logic [ccpm_pkg::CCPM_NUM_INST-1:0][9:0] duty_value
);
	localparam int NCH = ccpm_pkg::CCPM_NUM_INST;

	typedef struct packed {
		logic [5:0] ctrl;
		logic [15:0] cap;
		logic [1:0] sync;
		logic prev;
		logic [3:0] presc;
		logic match_d;
		logic latch;
		logic oe;
		logic flag;
		logic treset;
		logic [9:0] duty;
	} ccpm_ch_t;

	typedef struct packed {
		ccpm_ch_t [NCH-1:0] ch;
		logic adc_go;
	} ccpm_state_t;

	ccpm_state_t s;
	ccpm_state_t next_s;
	logic [NCH-1:0] e_rise;
	logic [NCH-1:0] e_fall;
	logic [NCH-1:0] m_rise;
	logic [NCH-1:0] cap_take;
	logic [NCH-1:0] flag_clr;
	logic [3:0] mode [NCH];

	ccpm_reg_if rif ();

	ccpm_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif)
	);

	function automatic logic inst_hit(input logic [7:0] addr, input int inst,
		input logic [7:0] ofs);
		return addr == 8'(inst * ccpm_pkg::CCPM_INST_STRIDE + ofs);
	endfunction

	function automatic logic addr_ok(input logic [7:0] addr);
		logic ok;
		ok = addr == ccpm_pkg::CCPM_FLAGS_OFS ||
			addr == ccpm_pkg::CCPM_STATUS_OFS;
		for (int i = 0; i < NCH; i++) begin
			ok = ok || inst_hit(addr, i, ccpm_pkg::CCPM_CTRL_OFS) ||
				inst_hit(addr, i, ccpm_pkg::CCPM_CAPL_OFS) ||
				inst_hit(addr, i, ccpm_pkg::CCPM_CAPH_OFS);
		end
		return ok;
	endfunction

	function automatic logic [1:0] grp(input logic [3:0] m);
		return m[3:2];
	endfunction

	function automatic logic is_cmp(input logic [3:0] m);
		return m == ccpm_pkg::CCPM_MODE_CMP_TOGGLE ||
			grp(m) == ccpm_pkg::CCPM_GRP_COMPARE;
	endfunction

	// Register read mux
	always_comb begin
		rif.rd_data = 32'h0000_0000;
		rif.rd_ok = addr_ok(rif.rd_addr);
		rif.wr_ok = addr_ok(rif.wr_addr);
		for (int i = 0; i < NCH; i++) begin
			if (inst_hit(rif.rd_addr, i, ccpm_pkg::CCPM_CTRL_OFS)) begin
				rif.rd_data[5:0] = s.ch[i].ctrl;
			end else if (inst_hit(rif.rd_addr, i,
				ccpm_pkg::CCPM_CAPL_OFS)) begin
				rif.rd_data[7:0] = s.ch[i].cap[7:0];
			end else if (inst_hit(rif.rd_addr, i,
				ccpm_pkg::CCPM_CAPH_OFS)) begin
				rif.rd_data[7:0] = s.ch[i].cap[15:8];
			end else if (rif.rd_addr == ccpm_pkg::CCPM_FLAGS_OFS) begin
				rif.rd_data[i] = s.ch[i].flag;
			end else if (rif.rd_addr == ccpm_pkg::CCPM_STATUS_OFS) begin
				rif.rd_data[2*i] = s.ch[i].sync[1];
				rif.rd_data[2*i+1] = s.ch[i].latch;
			end
		end
	end

	always_comb begin
		next_s = s;
		next_s.adc_go = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			mode[i] = s.ch[i].ctrl[ccpm_pkg::CCPM_MODE_LSB +: 4];
			// Pad value is sampled even when driven, so port writes
			// can raise captures
			next_s.ch[i].sync = {s.ch[i].sync[0], ccp_pin_in[i]};
			next_s.ch[i].prev = s.ch[i].sync[1];
			e_rise[i] = s.ch[i].sync[1] && !s.ch[i].prev;
			e_fall[i] = !s.ch[i].sync[1] && s.ch[i].prev;
			// Edge of the match, so a slow timer fires once per value
			next_s.ch[i].match_d = is_cmp(mode[i]) &&
				timer_count == s.ch[i].cap;
			m_rise[i] = next_s.ch[i].match_d && !s.ch[i].match_d;
			next_s.ch[i].treset = 1'b0;

			if (rif.wr_en && inst_hit(rif.wr_addr, i,
				ccpm_pkg::CCPM_CTRL_OFS)) begin
				next_s.ch[i].ctrl = rif.wr_data[5:0];
			end
			if (rif.wr_en && inst_hit(rif.wr_addr, i,
				ccpm_pkg::CCPM_CAPL_OFS)) begin
				next_s.ch[i].cap[7:0] = rif.wr_data;
			end
			if (rif.wr_en && inst_hit(rif.wr_addr, i,
				ccpm_pkg::CCPM_CAPH_OFS)) begin
				next_s.ch[i].cap[15:8] = rif.wr_data;
			end
			// Write one to clear; a same-cycle event below wins
			flag_clr[i] = rif.wr_en &&
				rif.wr_addr == ccpm_pkg::CCPM_FLAGS_OFS && rif.wr_data[i];
			if (flag_clr[i]) begin
				next_s.ch[i].flag = 1'b0;
			end

			cap_take[i] = 1'b0;
			if (grp(mode[i]) == ccpm_pkg::CCPM_GRP_CAPTURE) begin
				case (mode[i])
					ccpm_pkg::CCPM_MODE_CAP_FALL: begin
						cap_take[i] = e_fall[i];
					end
					ccpm_pkg::CCPM_MODE_CAP_RISE: begin
						cap_take[i] = e_rise[i];
					end
					default: begin
						// Count runs on across ratio changes
						if (e_rise[i]) begin
							next_s.ch[i].presc = s.ch[i].presc + 4'h1;
							cap_take[i] = (mode[i] ==
								ccpm_pkg::CCPM_MODE_CAP_RISE4) ?
								s.ch[i].presc[1:0] ==
								ccpm_pkg::CCPM_PRESC4_LAST :
								s.ch[i].presc ==
								ccpm_pkg::CCPM_PRESC16_LAST;
						end
					end
				endcase
			end else begin
				next_s.ch[i].presc = 4'h0;
			end
			// Capture beats a same-cycle software write; no overrun flag
			if (cap_take[i]) begin
				next_s.ch[i].cap = timer_count;
				next_s.ch[i].flag = 1'b1;
			end

			if (m_rise[i]) begin
				next_s.ch[i].flag = 1'b1;
				case (mode[i])
					ccpm_pkg::CCPM_MODE_CMP_TOGGLE: begin
						next_s.ch[i].latch = !s.ch[i].latch;
					end
					ccpm_pkg::CCPM_MODE_CMP_HIGH: begin
						next_s.ch[i].latch = 1'b1;
					end
					ccpm_pkg::CCPM_MODE_CMP_LOW: begin
						next_s.ch[i].latch = 1'b0;
					end
					ccpm_pkg::CCPM_MODE_CMP_TRIG: begin
						next_s.ch[i].treset = 1'b1;
						if (adc_enable) begin
							next_s.adc_go = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end

			// Soft-event and trigger modes leave the pin to the port
			next_s.ch[i].oe = mode[i] == ccpm_pkg::CCPM_MODE_CMP_TOGGLE ||
				mode[i] == ccpm_pkg::CCPM_MODE_CMP_HIGH ||
				mode[i] == ccpm_pkg::CCPM_MODE_CMP_LOW ||
				grp(mode[i]) == ccpm_pkg::CCPM_GRP_PWM;
			next_s.ch[i].duty = (grp(mode[i]) == ccpm_pkg::CCPM_GRP_PWM) ?
				{s.ch[i].cap[7:0],
				s.ch[i].ctrl[ccpm_pkg::CCPM_DUTY_LSB +: 2]} :
				10'h000;

			if (mode[i] == ccpm_pkg::CCPM_MODE_OFF) begin
				next_s.ch[i].latch = 1'b0;
				next_s.ch[i].presc = 4'h0;
				next_s.ch[i].match_d = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			for (int i = 0; i < NCH; i++) begin
				s.ch[i].ctrl <= ccpm_pkg::CCPM_CTRL_RST;
				s.ch[i].cap <= ccpm_pkg::CCPM_CAP_RST;
			end
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ccp_pin_out[i] = s.ch[i].latch;
			ccp_pin_oe[i] = s.ch[i].oe;
			timer_reset[i] = s.ch[i].treset;
			duty_value[i] = s.ch[i].duty;
		end
		adc_go_set = s.adc_go;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_shutdown;
		mode[0] == ccpm_pkg::CCPM_MODE_OFF |=>
			!ccp_pin_oe[0] && !ccp_pin_out[0] && s.ch[0].presc == 4'h0;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("unit not off");

	property p_toggle;
		mode[0] == ccpm_pkg::CCPM_MODE_CMP_TOGGLE && m_rise[0] |=>
			ccp_pin_out[0] != $past(ccp_pin_out[0]) && s.ch[0].flag;
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle");

	property p_high;
		mode[0] == ccpm_pkg::CCPM_MODE_CMP_HIGH && m_rise[0] |=>
			ccp_pin_out[0] && s.ch[0].flag && ccp_pin_oe[0];
	endproperty
	a_high: assert property (p_high) else $error("not driven high");

	property p_low;
		mode[0] == ccpm_pkg::CCPM_MODE_CMP_LOW && m_rise[0] |=>
			!ccp_pin_out[0] && s.ch[0].flag;
	endproperty
	a_low: assert property (p_low) else $error("not driven low");

	property p_soft;
		mode[0] == ccpm_pkg::CCPM_MODE_CMP_SOFT && m_rise[0] |=>
			s.ch[0].flag && !ccp_pin_oe[0] && $stable(ccp_pin_out[0]);
	endproperty
	a_soft: assert property (p_soft) else $error("pin touched");

	property p_trig;
		mode[0] == ccpm_pkg::CCPM_MODE_CMP_TRIG && m_rise[0] |=>
			timer_reset[0] && (adc_go_set == $past(adc_enable)) ##1
			!timer_reset[0];
	endproperty
	a_trig: assert property (p_trig) else $error("bad trigger");

	property p_duty;
		grp(mode[0]) == ccpm_pkg::CCPM_GRP_PWM |=>
			duty_value[0] == {$past(s.ch[0].cap[7:0]),
			$past(s.ch[0].ctrl[5:4])};
	endproperty
	a_duty: assert property (p_duty) else $error("bad duty");

	property p_capture;
		mode[0] == ccpm_pkg::CCPM_MODE_CAP_RISE && e_rise[0] |=>
			s.ch[0].cap == $past(timer_count) && s.ch[0].flag;
	endproperty
	a_capture: assert property (p_capture) else $error("no capture");

	property p_fall;
		mode[0] == ccpm_pkg::CCPM_MODE_CAP_FALL |-> cap_take[0] == e_fall[0];
	endproperty
	a_fall: assert property (p_fall) else $error("bad fall capture");

	property p_presc;
		mode[0] == ccpm_pkg::CCPM_MODE_CAP_RISE4 && e_rise[0] |=>
			s.ch[0].presc == 4'($past(s.ch[0].presc) + 4'h1);
	endproperty
	a_presc: assert property (p_presc) else $error("bad prescale");

	property p_sticky;
		s.ch[0].flag && !flag_clr[0] |=> s.ch[0].flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	property p_presc_clr;
		grp(mode[0]) != ccpm_pkg::CCPM_GRP_CAPTURE |=> s.ch[0].presc == 4'h0;
	endproperty
	a_presc_clr: assert property (p_presc_clr) else $error("presc kept");

	property p_one_edge;
		e_rise[0] |=> !e_rise[0];
	endproperty
	a_one_edge: assert property (p_one_edge) else $error("double edge");

	c_toggle: cover property (mode[0] == ccpm_pkg::CCPM_MODE_CMP_TOGGLE &&
		m_rise[0]);
	c_capture16: cover property (mode[0] == ccpm_pkg::CCPM_MODE_CAP_RISE16 &&
		cap_take[0]);
	c_trigger: cover property (adc_go_set);
endmodule
`default_nettype wire

// file: pkg/ccpm_pkg.sv
// Constants shared by the capture/compare unit and its register front end.
// Assumes a 32-bit AXI4-Lite bus with an 8-bit byte address.
package ccpm_pkg;
	localparam int CCPM_NUM_INST = 2;
	localparam int CCPM_ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] CCPM_CTRL_OFS = 8'h00;
	localparam logic [7:0] CCPM_CAPL_OFS = 8'h04;
	localparam logic [7:0] CCPM_CAPH_OFS = 8'h08;
	localparam logic [7:0] CCPM_INST_STRIDE = 8'h10;
	localparam logic [7:0] CCPM_FLAGS_OFS = 8'h20;
	localparam logic [7:0] CCPM_STATUS_OFS = 8'h24;

	// Control register fields
	localparam int CCPM_MODE_LSB = 0;
	localparam int CCPM_DUTY_LSB = 4;
	localparam logic [5:0] CCPM_CTRL_RST = 6'h00;
	localparam logic [15:0] CCPM_CAP_RST = 16'h0000;

	// Mode field codes
	localparam logic [3:0] CCPM_MODE_OFF = 4'h0;
	localparam logic [3:0] CCPM_MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] CCPM_MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] CCPM_MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] CCPM_MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] CCPM_MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] CCPM_MODE_CMP_HIGH = 4'h8;
	localparam logic [3:0] CCPM_MODE_CMP_LOW = 4'h9;
	localparam logic [3:0] CCPM_MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] CCPM_MODE_CMP_TRIG = 4'hb;
	localparam logic [1:0] CCPM_GRP_CAPTURE = 2'h1;
	localparam logic [1:0] CCPM_GRP_COMPARE = 2'h2;
	localparam logic [1:0] CCPM_GRP_PWM = 2'h3;

	// Capture edge prescaler: last count before a capture
	localparam logic [1:0] CCPM_PRESC4_LAST = 2'h3;
	localparam logic [3:0] CCPM_PRESC16_LAST = 4'hf;

	localparam logic [1:0] CCPM_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCPM_RESP_SLVERR = 2'h2;
endpackage

// file: pkg/ccpm_reg_if.sv
// Register access path between the bus slave and the unit's register file.
// Assumes both ends run on the same clock; all signals are combinational.
`timescale 1ns/1ps
`default_nettype none
interface ccpm_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	modport bus (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input wr_ok, input rd_data, input rd_ok);
	modport regs (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output wr_ok, output rd_data, output rd_ok);
endinterface
`default_nettype wire

// file: hw/ccpm_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes the register file decodes addresses combinationally.
`timescale 1ns/1ps
`default_nettype none
module ccpm_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ccpm_pkg::CCPM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ccpm_pkg::CCPM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	ccpm_reg_if.bus rif
);
	typedef struct packed {
		logic awready;
		logic aw_done;
		logic [7:0] awaddr;
		logic wready;
		logic w_done;
		logic [7:0] wdata;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ccpm_axs_t;

	ccpm_axs_t s;
	ccpm_axs_t next_s;

	always_comb begin
		next_s = s;
		rif.wr_en = 1'b0;
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_done = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_done = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wlane = s_axi_wstrb[0];
		end
		// Registers are one byte wide, so only lane 0 can change them
		if (s.aw_done && s.w_done && !s.bvalid) begin
			rif.wr_en = s.wlane && rif.wr_ok;
			next_s.bvalid = 1'b1;
			next_s.bresp = rif.wr_ok ? ccpm_pkg::CCPM_RESP_OKAY :
				ccpm_pkg::CCPM_RESP_SLVERR;
			next_s.aw_done = 1'b0;
			next_s.w_done = 1'b0;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = !next_s.aw_done && !next_s.bvalid;
		next_s.wready = !next_s.w_done && !next_s.bvalid;
		if (s_axi_arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rif.rd_data;
			next_s.rresp = rif.rd_ok ? ccpm_pkg::CCPM_RESP_OKAY :
				ccpm_pkg::CCPM_RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		rif.wr_addr = s.awaddr;
		rif.wr_data = s.wdata;
		rif.rd_addr = s_axi_araddr;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
endmodule
`default_nettype wire

// file: tb/ccpm_pin_model.sv
// Far side of the unit pins: an external source, or a load when driven.
// Assumes the bench sets the source level; no pull on the pad.
`timescale 1ns/1ps
`default_nettype none
module ccpm_pin_model (
	input wire logic [ccpm_pkg::CCPM_NUM_INST-1:0] src_level,
	input wire logic [ccpm_pkg::CCPM_NUM_INST-1:0] pin_out,
	input wire logic [ccpm_pkg::CCPM_NUM_INST-1:0] pin_oe,
	output logic [ccpm_pkg::CCPM_NUM_INST-1:0] pad
);
	// Undriven pin is a plain input; a driven pin reads back its own level
	assign pad = (pin_oe & pin_out) | (~pin_oe & src_level);
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench: AXI4-Lite register calls against the unit pair.
// Assumes the bench owns the timer count and the pin source levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, go;
	logic [1:0] bresp, rresp, pin_out, pin_oe, pad, trs;
	logic [1:0] lvl = 2'h0;
	logic [31:0] rdata, rd_d;
	logic [1:0] resp;
	logic [15:0] tmr = 16'h0000;
	logic tmr_run = 1'b0;
	logic adc_en = 1'b0;
	logic [1:0][9:0] duty;
	int n_errors = 0, tests_run = 0, n_trs = 0, n_go = 0;
	// {mode, clear first, out, oe, timer resets, conversion starts, adc on}
	logic [9:0] ct [8] = '{{4'h8, 6'b111000}, {4'h9, 6'b001000},
		{4'h2, 6'b011000}, {4'h2, 6'b001000}, {4'h2, 6'b011000},
		{4'ha, 6'b100000}, {4'hb, 6'b100111}, {4'hb, 6'b100100}};

	ccpm_top i_ccpm_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ccp_pin_in(pad), .ccp_pin_out(pin_out),
		.ccp_pin_oe(pin_oe), .timer_count(tmr), .adc_enable(adc_en),
		.timer_reset(trs), .adc_go_set(go), .duty_value(duty));
	ccpm_pin_model i_ccpm_pin_model (.src_level(lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pad(pad));

	always #4 aclk = ~aclk;

	// Timer counts on aclk only, so captures see a synchronous count
	always @(posedge aclk) begin
		if (|trs) tmr <= 16'h0000;
		else if (tmr_run) tmr <= tmr + 16'h0001;
		if (trs[0]) n_trs++;
		if (go) n_go++;
	end

	task test_done;
		if (n_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Leading edge keeps bready from being set twice in one step
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd_d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_d, e)
	endtask

	// Pulses stay well above two clocks so the synchroniser sees each one
	task edges(input int i, input int n);
		repeat (n) begin
			lvl[i] <= 1'b1;
			repeat (4) @(posedge aclk);
			lvl[i] <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask

	initial begin
		repeat (30000) @(posedge aclk);
		n_errors++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'h20, 32'h0);
		rd(8'h30);
		`CHK(resp, ccpm_pkg::CCPM_RESP_SLVERR)
		`CHK(rd_d, 32'h0)
		wr(8'h30, 32'hff);
		`CHK(resp, ccpm_pkg::CCPM_RESP_SLVERR)
		wr(8'h00, 32'h35);
		`CHK(resp, ccpm_pkg::CCPM_RESP_OKAY)
		wr(8'h20, 32'h3);
		`CHK(duty[0], 10'h000)
		tmr <= 16'h1234;
		edges(0, 1);
		rchk(8'h04, 32'h34);
		rchk(8'h08, 32'h12);
		rchk(8'h20, 32'h1);
		tmr <= 16'habcd;
		edges(0, 1);
		rchk(8'h04, 32'hcd);
		rchk(8'h08, 32'hab);
		wr(8'h20, 32'h1);
		rchk(8'h20, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h4);
		wr(8'h20, 32'h1);
		tmr <= 16'h1111;
		lvl[0] <= 1'b1;
		repeat (8) @(posedge aclk);
		rchk(8'h20, 32'h0);
		tmr <= 16'h2222;
		lvl[0] <= 1'b0;
		repeat (8) @(posedge aclk);
		rchk(8'h04, 32'h22);
		rchk(8'h20, 32'h1);
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, 32'h0);
			wr(8'h00, k ? 32'h7 : 32'h6);
			wr(8'h20, 32'h1);
			edges(0, k ? 15 : 3);
			rchk(8'h20, 32'h0);
			edges(0, 1);
			rchk(8'h20, 32'h1);
		end
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h6);
		wr(8'h20, 32'h1);
		edges(0, 2);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h6);
		edges(0, 3);
		rchk(8'h20, 32'h0);
		edges(0, 1);
		rchk(8'h20, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h6);
		wr(8'h20, 32'h1);
		edges(0, 2);
		wr(8'h00, 32'h7);
		edges(0, 13);
		rchk(8'h20, 32'h0);
		edges(0, 1);
		rchk(8'h20, 32'h1);
		wr(8'h20, 32'h3);
		wr(8'h10, 32'h5);
		tmr <= 16'h0f0f;
		edges(1, 1);
		rchk(8'h20, 32'h2);
		rchk(8'h14, 32'h0f);
		rchk(8'h04, 32'h22);
		wr(8'h10, 32'h0);
		wr(8'h04, 32'ha5);
		wr(8'h00, 32'h3c);
		repeat (2) @(posedge aclk);
		`CHK(duty[0], {8'ha5, 2'b11})
		wr(8'h04, 32'h40);
		wr(8'h08, 32'h0);
		foreach (ct[k]) begin
			if (ct[k][5]) wr(8'h00, 32'h0);
			wr(8'h00, {28'h0, ct[k][9:6]});
			wr(8'h20, 32'h3);
			adc_en <= ct[k][0];
			@(posedge aclk);
			n_trs = 0;
			n_go = 0;
			tmr <= 16'h0000;
			tmr_run <= 1'b1;
			repeat (80) @(posedge aclk);
			tmr_run <= 1'b0;
			`CHK(pin_out[0], ct[k][4])
			`CHK(pin_oe[0], ct[k][3])
			`CHK(n_trs == 1, ct[k][2])
			`CHK(n_go == 1, ct[k][1])
			`CHK(duty[0], 10'h000)
			rchk(8'h20, 32'h1);
			// A driven pin reads back its own level on the pad
			rchk(8'h24, {30'h0, ct[k][4], ct[k][4] & ct[k][3]});
		end
		test_done();
	end
endmodule
`default_nettype wire
